// ==== pkg/ttx_consts.svh ====
`ifndef TTX_CONSTS_SVH
`define TTX_CONSTS_SVH

// ==========================================================
// Clock and line timing
// ==========================================================
// Core clock period in ns
`define TTX_CLK_NS 16'h000A
// Sync-to-teletext offset in ns (10.2 us)
`define TTX_OFFSET_NS 16'h27D8
// Offset in clock cycles, least time so rounded up
`define TTX_OFFSET_CYC (12'((`TTX_OFFSET_NS + `TTX_CLK_NS - 16'h0001) / `TTX_CLK_NS))
// Edge-detect latency of the synchronised sync input
`define TTX_HS_LAT 12'h003
// Latency of the two-stage data synchroniser
`define TTX_DAT_LAT 12'h002

// ==========================================================
// Bit sequencer
// ==========================================================
// Teletext bits per line
`define TTX_LINE_BITS 9'h168
// Bits per repeating group
`define TTX_GRP_BITS 6'h25
// Clocks per group
`define TTX_GRP_CYC 8'h90
// Clocks for all bits of one line (9 groups plus 27 bits)
`define TTX_LINE_CYC 12'h57A
// Short and long bit lengths in clocks
`define TTX_SHORT_LEN 3'h3
`define TTX_LONG_LEN 3'h4
// Group positions of the short bits
`define TTX_SHORT_A 6'h0A
`define TTX_SHORT_B 6'h13
`define TTX_SHORT_C 6'h1C
`define TTX_SHORT_D 6'h25
// Request shortening per step of the width field, in clocks
`define TTX_WIDTH_STEP 12'h004

`endif

// ==== pkg/ttx_pkg.sv ====
package ttx_pkg;

    // ==========================================================
    // Types
    // ==========================================================
    // Line sequencer states
    typedef enum logic [1:0] {
        TTX_IDLE,
        TTX_WAIT,
        TTX_RUN
    } ttx_state_t;

    // Buffered word: short-bit flag and the data bit
    typedef logic [1:0] ttx_word_t;

endpackage

// ==== design/ttx_buf2.sv ====
`timescale 1ns/1ns
module ttx_buf2 #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 2
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word to store
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain side takes word
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    logic [WIDTH-1:0] mem_r [DEPTH]; // Entries
    logic [PW-1:0] wr_r; // Write index
    logic [PW-1:0] rd_r; // Read index
    logic [PW:0] cnt_r; // Fill level
    wire do_wr = in_valid & in_ready; // Accepted write
    wire do_rd = out_valid & out_ready; // Accepted read

    // Honest flags straight from the fill level
    // Level is one bit wider than an index, so full must be cast to that width
    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Write side
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
        end else if (do_wr) begin
            mem_r[wr_r] <= in_data;
            wr_r <= bump(wr_r);
        end
    end

    // Read side and level
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_rd) rd_r <= bump(rd_r);
            cnt_r <= cnt_r + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        end
    end

endmodule

// ==== design/ttx_inserter.sv ====
`timescale 1ns/1ns
`include "ttx_consts.svh"

module ttx_inserter import ttx_pkg::*; #(
    parameter int DLY_W = 8
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic hsync_n_in, // Horizontal sync pin, active low
    input wire logic teletext_data_in, // Serial teletext pin
    input wire logic teletext_enable_bit, // Teletext enable from mode logic
    input wire logic line_enable, // This line carries teletext
    input wire logic [3:0] request_width_field, // Request shortening code
    input wire logic [DLY_W-1:0] source_pipeline_delay, // Source delay, clocks
    output logic teletext_request_strobe, // Request to source, registered
    output logic insert_window, // Insertion window, registered
    output logic out_valid, // Sample to interpolator valid
    input wire logic out_ready, // Interpolator takes sample
    output logic out_bit, // Sampled teletext bit
    output logic out_short, // Sample came from a short bit
    output logic overrun // Sticky: a sample found no room
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic hs_s1_r; // Sync first stage
    logic hs_s2_r; // Sync second stage
    logic hs_s3_r; // Sync history for the edge
    logic dat_s1_r; // Data first stage
    logic dat_s2_r; // Data second stage

    // Both pins are asynchronous to the core clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hs_s1_r <= 1'b1;
            hs_s2_r <= 1'b1;
            hs_s3_r <= 1'b1;
            dat_s1_r <= 1'b0;
            dat_s2_r <= 1'b0;
        end else begin
            hs_s1_r <= hsync_n_in;
            hs_s2_r <= hs_s1_r;
            hs_s3_r <= hs_s2_r;
            dat_s1_r <= teletext_data_in;
            dat_s2_r <= dat_s1_r;
        end
    end

    // Leading (falling) edge of sync, seen only past the second stage
    wire hs_lead = hs_s3_r & ~hs_s2_r;

    // ==========================================================
    // Decode helpers
    // ==========================================================
    // True for the three-clock positions of a group
    function automatic logic is_short(input logic [5:0] pos);
        is_short = (pos == `TTX_SHORT_A) || (pos == `TTX_SHORT_B) ||
                   (pos == `TTX_SHORT_C) || (pos == `TTX_SHORT_D);
    endfunction

    // Clocks a bit at this position lasts
    function automatic logic [2:0] slot_len(input logic [5:0] pos);
        slot_len = is_short(pos) ? `TTX_SHORT_LEN : `TTX_LONG_LEN;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    ttx_state_t state_r; // Line sequencer state
    ttx_state_t state_nxt; // Next state
    logic [11:0] cnt_r; // Clocks since the sync edge was seen
    logic [2:0] slot_r; // Clock within the current bit
    logic [5:0] grp_r; // Bit position in group, 1..37
    logic [8:0] bit_r; // Bit number in line, 1..360
    logic req_r; // Request strobe
    logic win_r; // Insertion window
    logic ovr_r; // Overrun flag
    logic ovr_nxt; // Next overrun flag

    // ==========================================================
    // Timing points
    // ==========================================================
    // Count value at which the first bit reaches the data stage
    wire [11:0] win_at = `TTX_OFFSET_CYC - `TTX_HS_LAT;
    // Source lead time: its delay plus our data synchroniser
    wire [11:0] lead = 12'(source_pipeline_delay) + `TTX_DAT_LAT;
    // Rise early by the lead; a too-long delay clamps to the sync edge
    wire [11:0] rise_at = (lead > win_at) ? 12'h000 : win_at - lead;
    // Full width unless the field trims the tail
    wire [11:0] trim = 12'(request_width_field) * `TTX_WIDTH_STEP;
    wire [11:0] fall_at = rise_at + `TTX_LINE_CYC - trim;
    wire line_ok = teletext_enable_bit & line_enable;
    wire active = (state_r != TTX_IDLE);

    // ==========================================================
    // Bit slot decode
    // ==========================================================
    wire [2:0] cur_len = slot_len(grp_r);
    wire slot_end = (slot_r == cur_len - 3'h1);
    wire slot_mid = (slot_r == (cur_len >> 1));
    wire last_bit = (bit_r == `TTX_LINE_BITS);
    wire grp_end = (grp_r == `TTX_GRP_BITS);
    wire run = (state_r == TTX_RUN);
    wire push = run & slot_mid;
    wire buf_in_ready;

    // Next state of the line sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TTX_IDLE: begin
                // Each enabled line is started the same way
                if (hs_lead && line_ok) state_nxt = TTX_WAIT;
            end
            TTX_WAIT: begin
                // Window opens at the fixed offset from sync
                if (cnt_r == win_at) state_nxt = TTX_RUN;
            end
            TTX_RUN: begin
                // Line ends after the last bit slot
                if (slot_end && last_bit) state_nxt = TTX_IDLE;
            end
            default: begin
                state_nxt = TTX_IDLE;
            end
        endcase
        // Clearing enable closes request and window at once
        if (!teletext_enable_bit) state_nxt = TTX_IDLE;
        // A fresh sync edge restarts or skips the line
        else if (hs_lead) state_nxt = line_enable ? TTX_WAIT : TTX_IDLE;
    end

    // Overrun: a new miss wins over the clear at the next sync edge
    assign ovr_nxt = (push & ~buf_in_ready) | (ovr_r & ~hs_lead);

    // State, line counter and flags
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= TTX_IDLE;
            cnt_r <= 12'h000;
            ovr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ovr_r <= ovr_nxt;
            if (hs_lead) cnt_r <= 12'h000;
            else if (active) cnt_r <= cnt_r + 12'h001;
        end
    end

    // Request strobe, edges at programmed points
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_r <= 1'b0;
        end else if (state_nxt == TTX_IDLE || hs_lead) begin
            req_r <= 1'b0;
        end else if (cnt_r == rise_at) begin
            req_r <= 1'b1;
        end else if (cnt_r == fall_at) begin
            req_r <= 1'b0;
        end
    end

    // Window mirrors the running state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) win_r <= 1'b0;
        else win_r <= (state_nxt == TTX_RUN);
    end

    // Bit sequencer: 3 or 4 clocks per bit, 37-bit groups
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slot_r <= 3'h0;
            grp_r <= 6'h01;
            bit_r <= 9'h001;
        end else if (!run) begin
            slot_r <= 3'h0;
            grp_r <= 6'h01;
            bit_r <= 9'h001;
        end else if (slot_end) begin
            slot_r <= 3'h0;
            grp_r <= grp_end ? 6'h01 : grp_r + 6'h01;
            bit_r <= bit_r + 9'h001;
        end else begin
            slot_r <= slot_r + 3'h1;
        end
    end

    // ==========================================================
    // Sample buffer toward the interpolation filter
    // ==========================================================
    // The source cannot be paused, so a stall longer than two
    // samples is reported on the overrun flag instead of lost silently.
    ttx_buf2 #(
        .WIDTH(2),
        .DEPTH(2)
    ) u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data({is_short(grp_r), dat_s2_r}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_short, out_bit})
    );

    assign teletext_request_strobe = req_r;
    assign insert_window = win_r;
    assign overrun = ovr_r;

    // ==========================================================
    // Checks
    // ==========================================================
    logic [7:0] gcyc_r; // Clocks since the group began
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) gcyc_r <= 8'h00;
        else if (!run || (slot_end && grp_end)) gcyc_r <= 8'h00;
        else gcyc_r <= gcyc_r + 8'h01;
    end

    // Samples pushed so far in this line; cleared outside the run
    logic [8:0] npush_r; // Pushed samples in the line
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) npush_r <= 9'h000;
        else if (!run) npush_r <= 9'h000;
        else if (push) npush_r <= npush_r + 9'h001;
    end

    a_req_disabled: assert property (@(posedge core_clk) disable iff (rst)
        !teletext_enable_bit |=> !teletext_request_strobe)
        else $error("request active while teletext disabled");

    a_win_disabled: assert property (@(posedge core_clk) disable iff (rst)
        !teletext_enable_bit |=> !insert_window)
        else $error("window open while teletext disabled");

    a_win_offset: assert property (@(posedge core_clk) disable iff (rst)
        $rose(insert_window) |-> cnt_r == win_at + 12'h001)
        else $error("window opened off the sync offset");

    a_req_rise_pos: assert property (@(posedge core_clk) disable iff (rst)
        $rose(teletext_request_strobe) |-> cnt_r == rise_at + 12'h001)
        else $error("request rose at wrong point");

    a_req_full_width: assert property (@(posedge core_clk) disable iff (rst)
        $fell(teletext_request_strobe) && request_width_field == 4'h0 && !hs_lead
        && teletext_enable_bit |-> cnt_r == rise_at + `TTX_LINE_CYC + 12'h001)
        else $error("full-width request has wrong length");

    a_group_cycles: assert property (@(posedge core_clk) disable iff (rst)
        run && slot_end && grp_end |-> gcyc_r == `TTX_GRP_CYC - 8'h01)
        else $error("group did not take 144 clocks");

    a_short_slot: assert property (@(posedge core_clk) disable iff (rst)
        run && is_short(grp_r) |-> slot_r < `TTX_SHORT_LEN)
        else $error("short bit ran past three clocks");

    a_bit_range: assert property (@(posedge core_clk) disable iff (rst)
        run |-> bit_r >= 9'h001 && bit_r <= `TTX_LINE_BITS && grp_r <= `TTX_GRP_BITS)
        else $error("bit counter out of range");

    a_sample_mid: assert property (@(posedge core_clk) disable iff (rst)
        push |-> slot_r == (is_short(grp_r) ? 3'h1 : 3'h2))
        else $error("sample not at mid slot");

    a_line_skip: assert property (@(posedge core_clk) disable iff (rst)
        hs_lead && !line_enable |=> state_r == TTX_IDLE ##1 !insert_window)
        else $error("disabled line was not skipped");

    a_overrun_set: assert property (@(posedge core_clk) disable iff (rst)
        push && !buf_in_ready |=> overrun)
        else $error("lost sample not flagged");

    // A flag once set holds until the next sync edge clears it
    a_overrun_hold: assert property (@(posedge core_clk) disable iff (rst)
        overrun && !hs_lead |=> overrun)
        else $error("overrun flag cleared too early");

    // Trimmed request falls at its programmed tail point
    a_req_fall_pos: assert property (@(posedge core_clk) disable iff (rst)
        $fell(teletext_request_strobe) && !hs_lead && teletext_enable_bit
        && cnt_r != 12'h000 |-> cnt_r == fall_at + 12'h001)
        else $error("request fell at wrong point");

    // Request already stands when the first bit enters the window
    a_req_covers_win: assert property (@(posedge core_clk) disable iff (rst)
        $rose(insert_window) |-> teletext_request_strobe)
        else $error("window opened without request");

    // Two samples are never closer than a three-clock bit
    a_push_spacing: assert property (@(posedge core_clk) disable iff (rst)
        push |=> !push ##1 !push)
        else $error("samples taken too close together");

    // Every complete line offers the buffer exactly 360 samples, lost ones included
    a_line_bits: assert property (@(posedge core_clk) disable iff (rst)
        run && slot_end && last_bit |-> npush_r == `TTX_LINE_BITS)
        else $error("line sample count wrong");

endmodule

// ==== tb/ttx_source_model.sv ====
`timescale 1ns/1ns
`include "ttx_consts.svh"

// ==========================================================
// Teletext data source with a fixed pipeline delay
// ==========================================================
module ttx_source_model (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic teletext_request_strobe, // Request from the device
    input wire logic [7:0] source_pipeline_delay, // Own delay, clocks
    output logic teletext_data_in // Serial bits toward the device
);
    int phase_r; // Clocks since bit 1 began, negative while waiting
    logic req_q_r; // Request as seen at the last edge
    logic last_r; // Last level put on the pin
    int rem; // Clock position inside the group
    int acc; // Running start of each bit in the group
    int bitn; // Bit number inside the group
    int n; // Bit number inside the line
    logic live; // A line is being sent

    // ==========================================================
    // Decode the bit under the current clock
    // ==========================================================
    always_comb begin
        live = (phase_r >= 0) && (phase_r < int'(`TTX_LINE_CYC));
        rem = phase_r % int'(`TTX_GRP_CYC);
        acc = 0;
        bitn = 0;
        for (int b = 1; b <= int'(`TTX_GRP_BITS); b++) begin
            if (rem >= acc) begin
                bitn = b;
            end
            // Bits 10, 19, 28 and 37 are one clock shorter
            acc = acc + ((b % 9 == 1 && b > 1) ? 3 : 4);
        end
        n = (phase_r / int'(`TTX_GRP_CYC)) * int'(`TTX_GRP_BITS) + bitn;
        // Idle pin flips every cycle so that stale data never looks valid
        teletext_data_in = live ? ^(n[8:0] & 9'h0A5) : ~last_r;
    end

    // ==========================================================
    // Start a line a fixed delay after the request rises
    // ==========================================================
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_r <= 2000;
            req_q_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            req_q_r <= teletext_request_strobe;
            last_r <= teletext_data_in;
            if (teletext_request_strobe && !req_q_r) begin
                // Bit 1 reaches the pin delay clocks after the rise
                phase_r <= 1 - int'(source_pipeline_delay);
            end else if (phase_r < 2000) begin
                phase_r <= phase_r + 1;
            end
        end
    end
endmodule

// ==== tb/teletext_insertion_slicer_bench.sv ====
`timescale 1ns/1ns
`include "ttx_consts.svh"

// ==========================================================
// Comparison with counting
// ==========================================================
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end

module teletext_insertion_slicer_bench;
    logic core_clk, rst, hsync_n_in, teletext_data_in, teletext_enable_bit, line_enable;
    logic [3:0] request_width_field; // Request trim code
    logic [7:0] source_pipeline_delay; // Source delay, clocks
    logic teletext_request_strobe, insert_window, out_valid, out_ready;
    logic out_bit, out_short, overrun;
    int cyc, req_rise, win_rise, req_len, win_len, nsamp, m;
    int fail_count = 0; // Mismatches
    int cmp_count = 0; // Comparisons
    logic hs_q = 1'b1; // Sync pin one edge ago
    logic chk_on = 1'b1; // Sample contents are judged

    ttx_inserter #(.DLY_W(8)) dut (.core_clk(core_clk), .rst(rst), .hsync_n_in(hsync_n_in),
        .teletext_data_in(teletext_data_in), .teletext_enable_bit(teletext_enable_bit),
        .line_enable(line_enable), .request_width_field(request_width_field),
        .source_pipeline_delay(source_pipeline_delay),
        .teletext_request_strobe(teletext_request_strobe), .insert_window(insert_window),
        .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit),
        .out_short(out_short), .overrun(overrun));

    ttx_source_model src (.core_clk(core_clk), .rst(rst),
        .teletext_request_strobe(teletext_request_strobe),
        .source_pipeline_delay(source_pipeline_delay), .teletext_data_in(teletext_data_in));

    // ==========================================================
    // Clock and line monitor
    // ==========================================================
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // Edge positions counted from the sync pin fall; samples judged in order
    always @(posedge core_clk) begin
        hs_q <= hsync_n_in;
        if (hs_q && !hsync_n_in) begin
            cyc = 1;
            req_len = 0;
            win_len = 0;
            nsamp = 0;
        end else begin
            cyc++;
        end
        if (teletext_request_strobe === 1'b1) begin
            if (req_len == 0) req_rise = cyc;
            req_len++;
        end
        if (insert_window === 1'b1) begin
            if (win_len == 0) win_rise = cyc;
            win_len++;
        end
        if (out_valid === 1'b1 && out_ready) begin
            nsamp++;
            m = nsamp % 37;
            if (chk_on) begin
                `CHK(out_short, (m == 10 || m == 19 || m == 28 || m == 0))
                `CHK(out_bit, ^(nsamp[8:0] & 9'h0A5))
            end
        end
    end

    // ==========================================================
    // One sync period with optional stall and enable drop
    // ==========================================================
    task automatic run_line(input int dly, fld, en, le, st0, stl, off);
        @(posedge core_clk);
        source_pipeline_delay <= 8'(dly);
        request_width_field <= 4'(fld);
        line_enable <= le[0];
        teletext_enable_bit <= en[0];
        hsync_n_in <= 1'b0;
        for (int i = 1; i <= 2600; i++) begin
            @(posedge core_clk);
            hsync_n_in <= (i < 8) ? 1'b0 : 1'b1;
            out_ready <= (i >= st0 && i < st0 + stl) ? 1'b0 : 1'b1;
            teletext_enable_bit <= (i >= off) ? 1'b0 : en[0];
        end
    endtask

    // Full line; request moves with delay, window does not
    task automatic t_line(input int dly, fld, st0, stl);
        run_line(dly, fld, 1, 1, st0, stl, 9999);
        // Monitor counts from the first edge that sees the pin low
        `CHK(req_rise, int'(`TTX_OFFSET_CYC) - dly)
        `CHK(win_rise, int'(`TTX_OFFSET_CYC) + 2)
        `CHK(req_len, int'(`TTX_LINE_CYC) - 4 * fld)
        `CHK(win_len, int'(`TTX_LINE_CYC))
        `CHK(nsamp, int'(`TTX_LINE_BITS))
        `CHK(overrun, 1'b0)
        $display("test line delay %0d field %0d done", dly, fld);
    endtask

    // Global and per-line enables keep the request and window shut
    task automatic t_gated();
        run_line(4, 0, 0, 1, 0, 0, 9999);
        `CHK(req_len + win_len + nsamp, 0)
        run_line(4, 0, 1, 0, 0, 0, 9999);
        `CHK(req_len + win_len + nsamp, 0)
        $display("test gated done");
    endtask

    // Long stall overflows the two-entry buffer; next sync clears it
    task automatic t_overrun();
        chk_on = 1'b0;
        run_line(4, 0, 1, 1, 1100, 40, 9999);
        `CHK(overrun, 1'b1)
        `CHK(nsamp < int'(`TTX_LINE_BITS), 1'b1)
        chk_on = 1'b1;
        $display("test overrun done");
    endtask

    // Enable dropped in mid-line cuts the window short
    task automatic t_abort();
        run_line(4, 0, 1, 1, 0, 0, 1500);
        `CHK(win_len > 470 && win_len < 490, 1'b1)
        `CHK({teletext_request_strobe, insert_window}, 2'h0)
        $display("test abort done");
    endtask

    // ==========================================================
    // Verdict, watchdog and main sequence
    // ==========================================================
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Seven lines of 2601 clocks need about 182 us
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        hsync_n_in = 1'b1;
        teletext_enable_bit = 1'b0;
        line_enable = 1'b0;
        request_width_field = 4'h0;
        source_pipeline_delay = 8'h04;
        out_ready = 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        // Outputs idle after reset
        `CHK({teletext_request_strobe, insert_window, out_valid, overrun}, 4'h0)
        t_line(4, 0, 0, 0);
        t_line(20, 3, 1200, 5);
        t_gated();
        t_overrun();
        t_line(4, 0, 0, 0);
        t_abort();
        complete_run();
    end
endmodule
